// ---- rtl/lqr_pkg.sv ----
/*
  Shared constants and types for the queued log receive command:
  command and subcommand codes, taskfile field positions, status and
  error byte layout, host register map and state encodings.
  Assumes a single clk_sys domain at 100 MHz and synchronous reset.
*/
package lqr_pkg;
  // ****************************************
  // Command decode
  // ****************************************
  localparam logic [7:0] LQR_CMD_QUEUED_RX = 8'h65;
  localparam logic [4:0] LQR_SUB_LOG_READ  = 5'h01;
  localparam int         LQR_SUB_W         = 5;
  localparam int         LQR_SUB_LSB       = 8;
  localparam int         LQR_TAG_W         = 5;
  localparam int         LQR_TAG_LSB       = 3;
  localparam int         LQR_ACT_W         = 32;
  localparam logic [7:0] LQR_DEVICE_BYTE   = 8'h40;

  // ****************************************
  // Status and error bytes
  // ****************************************
  localparam int         LQR_ST_BUSY    = 7;
  localparam int         LQR_ST_READY   = 6;
  localparam int         LQR_ST_ERR     = 0;
  localparam int         LQR_ER_ABORTED = 2;
  localparam logic [7:0] LQR_STATUS_RST = 8'h40;
  localparam logic [7:0] LQR_ERROR_RST  = 8'h00;

  // ****************************************
  // Host register map
  // ****************************************
  localparam logic [11:0] LQR_OFS_ISSUE    = 12'h000;
  localparam logic [11:0] LQR_OFS_COUNT    = 12'h004;
  localparam logic [11:0] LQR_OFS_LBA_LO   = 12'h008;
  localparam logic [11:0] LQR_OFS_LBA_HI   = 12'h00C;
  localparam logic [11:0] LQR_OFS_RESULT   = 12'h010;
  localparam logic [11:0] LQR_OFS_DONE     = 12'h014;
  localparam logic [11:0] LQR_OFS_IRQ_STAT = 12'h018;
  localparam logic [11:0] LQR_OFS_IRQ_MASK = 12'h01C;
  localparam int          LQR_ISS_TAG_LSB  = 8;
  localparam int          LQR_ISS_SUB_LSB  = 16;
  localparam int          LQR_ISS_START    = 31;
  localparam int          LQR_IRQ_ACK      = 0;
  localparam int          LQR_IRQ_ERR      = 1;
  localparam int          LQR_IRQ_SDB      = 2;
  localparam int          LQR_IRQ_W        = 3;

  // ****************************************
  // State encodings
  // ****************************************
  typedef enum logic [1:0] {
    LQR_D_IDLE = 2'b01,
    LQR_D_LOG  = 2'b10
  } lqr_dev_state_t;

  typedef enum logic [2:0] {
    LQR_H_IDLE = 3'b001,
    LQR_H_SEND = 3'b010,
    LQR_H_WAIT = 3'b100
  } lqr_host_state_t;
endpackage

// ---- rtl/lqr_if.sv ----
/*
  Link between host controller end and device end: command frame,
  register frame back and set-device-bits frame back.
  Two-byte taskfile fields are {previous, current}. Same clock both ends.
*/
interface lqr_if;
  logic        h2d_valid;
  logic        h2d_ready;
  logic [7:0]  h2d_command;
  logic [15:0] h2d_feature;
  logic [15:0] h2d_count;
  logic [15:0] h2d_sect;
  logic [15:0] h2d_cyl_lo;
  logic [15:0] h2d_cyl_hi;
  logic [7:0]  h2d_device;
  logic        d2h_valid;
  logic [7:0]  d2h_status;
  logic [7:0]  d2h_error;
  logic        sdb_valid;
  logic        sdb_intr;
  logic [31:0] sdb_act;

  modport dev (
    input  h2d_valid, h2d_command, h2d_feature, h2d_count, h2d_sect,
    input  h2d_cyl_lo, h2d_cyl_hi, h2d_device,
    output h2d_ready, d2h_valid, d2h_status, d2h_error,
    output sdb_valid, sdb_intr, sdb_act
  );
  modport host (
    output h2d_valid, h2d_command, h2d_feature, h2d_count, h2d_sect,
    output h2d_cyl_lo, h2d_cyl_hi, h2d_device,
    input  h2d_ready, d2h_valid, d2h_status, d2h_error,
    input  sdb_valid, sdb_intr, sdb_act
  );
endinterface

// ---- rtl/lqr_device.sv ----
/*
  Device end: decodes the queued receive command, hands log reads to
  the log engine, reports early errors in a register frame and
  queued completions in set-device-bits frames.
  Assumes the host keeps its frame stable while h2d_valid is high.
*/
// Functional notes
// - Code 65h is the queued receive command
// - Subcommand 1h log read; others reserved
// - Decode outputs per subcommand, not code
// - Subcommand bits 4:0 equal 01h
// - Current feature byte is count low
// - Previous feature byte is count high
// - Sector number bytes: address 7:0, 31:24
// - Cylinder low bytes: address 15:8, 39:32
// - Cylinder high bytes: address 23:16, 47:40
// - Completion frame: interrupt set, one bit/tag
// - Early error answered by register frame
module lqr_device
  import lqr_pkg::*;
#(
  parameter int NUM_TAGS = 32
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  lqr_if.dev               link,
  output logic             log_req,
  output logic [15:0]      log_count,
  output logic [47:0]      log_lba,
  output logic [4:0]       log_tag,
  input  wire logic        log_ack,
  input  wire logic        done_valid,
  input  wire logic [4:0]  done_tag
);

  // ****************************************
  // Parameter check
  // ****************************************
  if (NUM_TAGS < 1 || NUM_TAGS > LQR_ACT_W) begin : g_bad_tags
    $error("NUM_TAGS must be 1 to 32");
  end

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    lqr_dev_state_t        state;
    logic                  h2d_ready;
    logic                  d2h_valid;
    logic [7:0]            status;
    logic [7:0]            error;
    logic                  sdb_valid;
    logic                  sdb_intr;
    logic [LQR_ACT_W-1:0]  sdb_act;
    logic [LQR_ACT_W-1:0]  pend;
    logic [LQR_ACT_W-1:0]  outstanding;
    logic                  log_req;
    logic [15:0]           log_count;
    logic [47:0]           log_lba;
    logic [LQR_TAG_W-1:0]  log_tag;
  } lqr_dev_q_t;

  lqr_dev_q_t q;
  lqr_dev_q_t next_q;

  logic [LQR_TAG_W-1:0] rx_tag;
  logic [LQR_SUB_W-1:0] rx_sub;
  logic                 rx_good;
  logic                 rx_tag_free;
  logic                 rx_take;
  logic [LQR_ACT_W-1:0] done_mask;
  logic [LQR_ACT_W-1:0] tag_mask;

  // ****************************************
  // Frame field decode
  // ****************************************
  // tag from count bits
  assign rx_tag  = link.h2d_count[LQR_TAG_LSB +: LQR_TAG_W];
  assign rx_sub  = link.h2d_count[LQR_SUB_LSB +: LQR_SUB_W];
  assign rx_take = q.h2d_ready && link.h2d_valid;

  // Tags of NUM_TAGS and up or still queued are refused
  assign rx_tag_free = (32'(rx_tag) < NUM_TAGS) && !q.outstanding[rx_tag];

  assign rx_good = (link.h2d_command == LQR_CMD_QUEUED_RX)
                && (rx_sub == LQR_SUB_LOG_READ)
                && rx_tag_free;

  // Per-tag decode of completion and acceptance
  for (genvar i = 0; i < LQR_ACT_W; i++) begin : g_tag
    localparam logic [LQR_TAG_W-1:0] TAG_ID = LQR_TAG_W'(i);
    assign done_mask[i] = done_valid && (done_tag == TAG_ID);
    assign tag_mask[i]  = (rx_tag == TAG_ID);
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_q           = q;
    next_q.d2h_valid = 1'b0;
    next_q.sdb_valid = 1'b0;
    next_q.sdb_intr  = 1'b0;

    case (q.state)
      LQR_D_IDLE: begin
        if (rx_take) begin
          if (rx_good) begin
            // fields taken only for log read
            next_q.log_count = link.h2d_feature;
            next_q.log_lba = {link.h2d_cyl_hi[15:8], link.h2d_cyl_lo[15:8],
                              link.h2d_sect[15:8], link.h2d_cyl_hi[7:0],
                              link.h2d_cyl_lo[7:0], link.h2d_sect[7:0]};
            next_q.log_tag     = rx_tag;
            next_q.log_req     = 1'b1;
            next_q.outstanding = q.outstanding | tag_mask;
            next_q.status      = LQR_STATUS_RST;
            next_q.error       = LQR_ERROR_RST;
            next_q.h2d_ready   = 1'b0;
            next_q.state       = LQR_D_LOG;
          end else begin
            next_q.status               = LQR_STATUS_RST;
            next_q.status[LQR_ST_ERR]   = 1'b1;
            next_q.error                = LQR_ERROR_RST;
            next_q.error[LQR_ER_ABORTED] = 1'b1;
          end
          // Register frame answers every command
          next_q.d2h_valid = 1'b1;
        end
      end
      LQR_D_LOG: begin
        // Busy until the log engine takes the job
        if (log_ack) begin
          next_q.log_req   = 1'b0;
          next_q.h2d_ready = 1'b1;
          next_q.state     = LQR_D_IDLE;
        end
      end
      default: begin
        // Recover from a stray state code
        next_q.state     = LQR_D_IDLE;
        next_q.log_req   = 1'b0;
        next_q.h2d_ready = 1'b1;
      end
    endcase

    next_q.outstanding = next_q.outstanding & ~done_mask;
    // Register frame goes first; completions wait
    if (!next_q.d2h_valid && (q.pend | done_mask) != '0) begin
      next_q.sdb_valid = 1'b1;
      next_q.sdb_intr  = 1'b1;
      next_q.sdb_act   = q.pend | done_mask;
      next_q.pend      = '0;
    end else begin
      next_q.pend = q.pend | done_mask;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // Reset leaves the device idle and ready
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q.state       <= LQR_D_IDLE;
      q.h2d_ready   <= 1'b1;
      q.d2h_valid   <= 1'b0;
      q.status      <= LQR_STATUS_RST;
      q.error       <= LQR_ERROR_RST;
      q.sdb_valid   <= 1'b0;
      q.sdb_intr    <= 1'b0;
      q.sdb_act     <= '0;
      q.pend        <= '0;
      q.outstanding <= '0;
      q.log_req     <= 1'b0;
      q.log_count   <= '0;
      q.log_lba     <= '0;
      q.log_tag     <= '0;
    end else begin
      q <= next_q;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Link answers and job hand-off
  assign link.h2d_ready  = q.h2d_ready;
  assign link.d2h_valid  = q.d2h_valid;
  assign link.d2h_status = q.status;
  assign link.d2h_error  = q.error;
  assign link.sdb_valid  = q.sdb_valid;
  assign link.sdb_intr   = q.sdb_intr;
  assign link.sdb_act    = q.sdb_act;
  assign log_req         = q.log_req;
  assign log_count       = q.log_count;
  assign log_lba         = q.log_lba;
  assign log_tag         = q.log_tag;

endmodule // lqr_device

// ---- rtl/lqr_host.sv ----
/*
  Host controller end: software sets up a log read over APB, the
  block sends the command frame and collects register and
  set-device-bits frames, with sticky interrupt status.
  Assumes APB master in the clk_sys domain.
*/
module lqr_host
  import lqr_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  lqr_if.host              link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    lqr_host_state_t       state;
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
    logic [7:0]            cmd;
    logic [LQR_TAG_W-1:0]  tag;
    logic [LQR_SUB_W-1:0]  sub;
    logic [15:0]           count;
    logic [47:0]           lba;
    logic [15:0]           result;
    logic [LQR_ACT_W-1:0]  done;
    logic [LQR_IRQ_W-1:0]  irq_stat;
    logic [LQR_IRQ_W-1:0]  irq_mask;
    logic                  irq;
    logic                  h2d_valid;
    logic [7:0]            h2d_command;
    logic [15:0]           h2d_feature;
    logic [15:0]           h2d_count;
    logic [15:0]           h2d_sect;
    logic [15:0]           h2d_cyl_lo;
    logic [15:0]           h2d_cyl_hi;
  } lqr_host_q_t;

  lqr_host_q_t q;
  lqr_host_q_t next_q;

  logic                 acc;
  logic                 wr;
  logic                 mapped;
  logic [LQR_IRQ_W-1:0] ev;

  assign acc    = psel && penable;
  assign wr     = acc && pwrite && q.pready && !q.pslverr;
  assign mapped = (paddr[11:5] == '0) && (paddr[1:0] == 2'b00);

  always_comb begin
    next_q = q;
    ev     = '0;
    // Bus answer one cycle into the access phase
    next_q.pready  = acc && !q.pready;
    next_q.pslverr = acc && !q.pready && !mapped;
    next_q.prdata  = '0;
    if (acc && !q.pready && !pwrite) begin
      case (paddr)
        LQR_OFS_ISSUE:    next_q.prdata = {q.state != LQR_H_IDLE, 10'h000, q.sub,
                                           3'h0, q.tag, q.cmd};
        LQR_OFS_COUNT:    next_q.prdata = {16'h0000, q.count};
        LQR_OFS_LBA_LO:   next_q.prdata = q.lba[31:0];
        LQR_OFS_LBA_HI:   next_q.prdata = {16'h0000, q.lba[47:32]};
        LQR_OFS_RESULT:   next_q.prdata = {16'h0000, q.result};
        LQR_OFS_DONE:     next_q.prdata = q.done;
        LQR_OFS_IRQ_STAT: next_q.prdata = {29'h0, q.irq_stat};
        LQR_OFS_IRQ_MASK: next_q.prdata = {29'h0, q.irq_mask};
        default:          next_q.prdata = '0;
      endcase
    end

    case (q.state)
      LQR_H_IDLE: begin
        if (wr && paddr == LQR_OFS_ISSUE && pwdata[LQR_ISS_START]) begin
          next_q.h2d_valid   = 1'b1;
          next_q.h2d_command = pwdata[7:0];
          next_q.h2d_feature = q.count;
          next_q.h2d_count   = {3'h0, pwdata[LQR_ISS_SUB_LSB +: LQR_SUB_W],
                                pwdata[LQR_ISS_TAG_LSB +: LQR_TAG_W], 3'h0};
          next_q.h2d_sect    = {q.lba[31:24], q.lba[7:0]};
          next_q.h2d_cyl_lo  = {q.lba[39:32], q.lba[15:8]};
          next_q.h2d_cyl_hi  = {q.lba[47:40], q.lba[23:16]};
          next_q.state       = LQR_H_SEND;
        end
      end
      LQR_H_SEND: begin
        if (link.h2d_ready) begin
          next_q.h2d_valid = 1'b0;
          next_q.state     = LQR_H_WAIT;
        end
      end
      LQR_H_WAIT: begin
        if (link.d2h_valid) begin
          next_q.state = LQR_H_IDLE;
        end
      end
      default: begin
        next_q.state     = LQR_H_IDLE;
        next_q.h2d_valid = 1'b0;
      end
    endcase

    if (wr) begin
      case (paddr)
        LQR_OFS_ISSUE: begin
          next_q.cmd = pwdata[7:0];
          next_q.tag = pwdata[LQR_ISS_TAG_LSB +: LQR_TAG_W];
          next_q.sub = pwdata[LQR_ISS_SUB_LSB +: LQR_SUB_W];
        end
        LQR_OFS_COUNT:    next_q.count = pwdata[15:0];
        LQR_OFS_LBA_LO:   next_q.lba[31:0] = pwdata;
        LQR_OFS_LBA_HI:   next_q.lba[47:32] = pwdata[15:0];
        LQR_OFS_IRQ_MASK: next_q.irq_mask = pwdata[LQR_IRQ_W-1:0];
        default: begin
        end
      endcase
    end

    // Sticky events; a set in the clear cycle wins
    if (link.d2h_valid) begin
      next_q.result = {link.d2h_error, link.d2h_status};
      ev[LQR_IRQ_ACK] = !link.d2h_status[LQR_ST_ERR];
      ev[LQR_IRQ_ERR] = link.d2h_status[LQR_ST_ERR];
    end
    ev[LQR_IRQ_SDB] = link.sdb_valid && link.sdb_intr;
    next_q.done = q.done & ~((wr && paddr == LQR_OFS_DONE) ? pwdata : 32'h0);
    if (link.sdb_valid) begin
      next_q.done = next_q.done | link.sdb_act;
    end
    next_q.irq_stat = q.irq_stat & ~((wr && paddr == LQR_OFS_IRQ_STAT)
                      ? pwdata[LQR_IRQ_W-1:0] : 3'h0);
    next_q.irq_stat = next_q.irq_stat | ev;
    next_q.irq = |(next_q.irq_stat & next_q.irq_mask);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '{state: LQR_H_IDLE, default: '0};
    end else begin
      q <= next_q;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign prdata           = q.prdata;
  assign pready           = q.pready;
  assign pslverr          = q.pslverr;
  assign irq              = q.irq;
  assign link.h2d_valid   = q.h2d_valid;
  assign link.h2d_command = q.h2d_command;
  assign link.h2d_feature = q.h2d_feature;
  assign link.h2d_count   = q.h2d_count;
  assign link.h2d_sect    = q.h2d_sect;
  assign link.h2d_cyl_lo  = q.h2d_cyl_lo;
  assign link.h2d_cyl_hi  = q.h2d_cyl_hi;
  // device byte bit 6 set, bit 4 clear
  assign link.h2d_device  = LQR_DEVICE_BYTE;

endmodule // lqr_host

// ---- tb/lqr_props.sv ----
/*
  Concurrent checks on the link between host end and device end.
  Assumes one clk_sys domain and synchronous active-high rst.
*/
module lqr_props
  import lqr_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        h2d_valid,
  input wire logic        h2d_ready,
  input wire logic [7:0]  h2d_command,
  input wire logic [15:0] h2d_count,
  input wire logic [7:0]  h2d_device,
  input wire logic        d2h_valid,
  input wire logic [7:0]  d2h_status,
  input wire logic [7:0]  d2h_error,
  input wire logic        sdb_valid,
  input wire logic        sdb_intr,
  input wire logic [31:0] sdb_act
);
  // ****************************************
  // Link properties
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_code_abort;
    h2d_valid && h2d_ready && h2d_command != 8'h65 |=> d2h_valid && d2h_status == 8'h41 && d2h_error == 8'h04;
  endproperty
  a_code_abort: assert property (p_code_abort) else $error("foreign code not aborted");
  property p_sub_abort;
    h2d_valid && h2d_ready && h2d_count[12:8] != 5'h01 |=> d2h_valid && d2h_status == 8'h41;
  endproperty
  a_sub_abort: assert property (p_sub_abort) else $error("reserved subcommand not aborted");
  property p_d2h_cause;
    d2h_valid |-> $past(h2d_valid) && $past(h2d_ready);
  endproperty
  a_d2h_cause: assert property (p_d2h_cause) else $error("register frame without command");
  property p_busy_entry;
    $fell(h2d_ready) |-> d2h_valid && d2h_status == 8'h40 && d2h_error == 8'h00;
  endproperty
  a_busy_entry: assert property (p_busy_entry) else $error("busy without good answer");
  property p_err_ready;
    d2h_valid && d2h_status[0] |-> h2d_ready && d2h_error == 8'h04;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error frame left device busy");
  property p_sdb;
    sdb_valid |-> sdb_intr && sdb_act != 32'h0;
  endproperty
  a_sdb: assert property (p_sdb) else $error("completion frame malformed");
  property p_dev_byte;
    h2d_valid |-> h2d_device == 8'h40;
  endproperty
  a_dev_byte: assert property (p_dev_byte) else $error("device byte wrong");
  property p_tag_pos;
    h2d_valid |-> h2d_count[2:0] == 3'h0 && h2d_count[15:13] == 3'h0;
  endproperty
  a_tag_pos: assert property (p_tag_pos) else $error("count byte spare bits set");
endmodule // lqr_props

// ---- tb/lqr_tb_top.sv ----
/*
  Bench for host and device ends joined by lqr_if; APB master tasks.
  Assumes the device is built with NUM_TAGS of 16.
*/
module lqr_tb_top
  import lqr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, irq, er;
  logic        log_req, log_ack = 1'b0, done_valid = 1'b0;
  logic [15:0] log_count;
  logic [47:0] log_lba;
  logic [4:0]  log_tag, done_tag = 5'h00;
  logic [87:0] cap;
  int          n_errors = 0, num_checks = 0;
  logic [17:0] bad [5] = '{{8'h64, 5'h01, 5'h02}, {8'h65, 5'h00, 5'h02}, {8'h65, 5'h02, 5'h02},
                           {8'h65, 5'h1F, 5'h02}, {8'h65, 5'h01, 5'h14}};

  always #5 clk_sys = ~clk_sys;
  lqr_if lqr_if_i ();
  lqr_device #(.NUM_TAGS(16)) lqr_device_i (.clk_sys(clk_sys), .rst(rst), .link(lqr_if_i), .log_req(log_req),
    .log_count(log_count), .log_lba(log_lba), .log_tag(log_tag), .log_ack(log_ack), .done_valid(done_valid),
    .done_tag(done_tag));
  lqr_host lqr_host_i (.clk_sys(clk_sys), .rst(rst), .link(lqr_if_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  lqr_props lqr_props_i (.clk_sys(clk_sys), .rst(rst), .h2d_valid(lqr_if_i.h2d_valid),
    .h2d_ready(lqr_if_i.h2d_ready), .h2d_command(lqr_if_i.h2d_command), .h2d_count(lqr_if_i.h2d_count),
    .h2d_device(lqr_if_i.h2d_device), .d2h_valid(lqr_if_i.d2h_valid), .d2h_status(lqr_if_i.d2h_status),
    .d2h_error(lqr_if_i.d2h_error), .sdb_valid(lqr_if_i.sdb_valid), .sdb_intr(lqr_if_i.sdb_intr),
    .sdb_act(lqr_if_i.sdb_act));

  // Frame fields at the edge the device takes them
  always @(posedge clk_sys) begin
    if (lqr_if_i.h2d_valid && lqr_if_i.h2d_ready) begin
      cap <= {lqr_if_i.h2d_feature, lqr_if_i.h2d_count, lqr_if_i.h2d_sect, lqr_if_i.h2d_cyl_lo,
              lqr_if_i.h2d_cyl_hi, lqr_if_i.h2d_device};
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      n_errors++;
      finish_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check({er, rd}, {1'b0, exp});
  endtask

  task automatic issue(input logic [7:0] c, input logic [4:0] s, input logic [4:0] t);
    int i;
    xfer(1'b1, LQR_OFS_ISSUE, {1'b1, 10'h000, s, 3'h0, t, c});
    i = 0;
    do begin
      xfer(1'b0, LQR_OFS_ISSUE, 32'h0);
      i++;
    end while (rd[31] !== 1'b0 && i < 50);
    if (i >= 50) begin
      n_errors++;
      finish_test();
    end
  endtask

  task automatic ack_log;
    int i;
    i = 0;
    while (log_req !== 1'b1 && i < 50) begin
      @(posedge clk_sys);
      i++;
    end
    if (i >= 50) begin
      n_errors++;
      finish_test();
    end
    log_ack <= 1'b1;
    @(posedge clk_sys);
    log_ack <= 1'b0;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check({lqr_if_i.h2d_ready, lqr_if_i.d2h_status}, 9'h140);
    for (int a = 0; a < 32; a += 4) rchk(a[11:0], 32'h0);
    xfer(1'b0, 12'h020, 32'h0);
    check({er, rd}, 33'h100000000);
    $display("test reset and map done");
    xfer(1'b1, LQR_OFS_IRQ_MASK, 32'h7);
    xfer(1'b1, LQR_OFS_COUNT, 32'h0000A55A);
    xfer(1'b1, LQR_OFS_LBA_LO, 32'h89ABCDEF);
    xfer(1'b1, LQR_OFS_LBA_HI, 32'h00001234);
    issue(8'h65, 5'h01, 5'h05);
    check({log_req, log_count}, 17'h1A55A);
    check(log_lba, 48'h123489ABCDEF);
    check(log_tag, 5'h05);
    check(cap, 88'hA55A_0128_89EF_34CD_12AB_40);
    rchk(LQR_OFS_RESULT, 32'h0040);
    rchk(LQR_OFS_IRQ_STAT, 32'h1);
    check(irq, 1'b1);
    ack_log();
    @(posedge clk_sys);
    done_valid <= 1'b1;
    done_tag <= 5'h05;
    @(posedge clk_sys);
    done_valid <= 1'b0;
    rchk(LQR_OFS_DONE, 32'h20);
    rchk(LQR_OFS_IRQ_STAT, 32'h5);
    xfer(1'b1, LQR_OFS_IRQ_STAT, 32'h5);
    xfer(1'b1, LQR_OFS_DONE, 32'h20);
    rchk(LQR_OFS_IRQ_STAT, 32'h0);
    check(irq, 1'b0);
    $display("test log read done");
    issue(8'h65, 5'h01, 5'h07);
    ack_log();
    issue(8'h65, 5'h01, 5'h07);
    rchk(LQR_OFS_RESULT, 32'h0441);
    for (int k = 0; k < 5; k++) begin
      xfer(1'b1, LQR_OFS_IRQ_STAT, 32'h7);
      issue(bad[k][17:10], bad[k][9:5], bad[k][4:0]);
      rchk(LQR_OFS_RESULT, 32'h0441);
      rchk(LQR_OFS_IRQ_STAT, 32'h2);
      check({irq, log_req}, 2'b10);
    end
    $display("test aborts done");
    xfer(1'b1, LQR_OFS_IRQ_MASK, 32'h0);
    rchk(LQR_OFS_IRQ_STAT, 32'h2);
    check(irq, 1'b0);
    issue(8'h65, 5'h01, 5'h09);
    ack_log();
    xfer(1'b1, LQR_OFS_IRQ_MASK, 32'h4);
    @(posedge clk_sys);
    check(irq, 1'b0);
    @(posedge clk_sys);
    done_valid <= 1'b1;
    done_tag <= 5'h07;
    @(posedge clk_sys);
    done_tag <= 5'h09;
    @(posedge clk_sys);
    done_valid <= 1'b0;
    rchk(LQR_OFS_DONE, 32'h280);
    rchk(LQR_OFS_IRQ_STAT, 32'h7);
    check(irq, 1'b1);
    xfer(1'b1, LQR_OFS_IRQ_STAT, 32'h7);
    rchk(LQR_OFS_IRQ_STAT, 32'h0);
    check(irq, 1'b0);
    $display("test completion and mask done");
    finish_test();
  end
endmodule // lqr_tb_top
